//--- pkg/asgio_pkg.sv
/*
  Constants and carrier types for the per-axis general I/O block:
  register offsets, field positions, reset values and motion status.
  Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
*/
`default_nettype none
package asgio_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_OUT_DATA = 8'h00;
  localparam logic [7:0] ADDR_MODE     = 8'h04;
  localparam logic [7:0] ADDR_X_STATUS = 8'h08;
  localparam logic [7:0] ADDR_Y_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_X_CMP_P  = 8'h10;
  localparam logic [7:0] ADDR_X_CMP_N  = 8'h14;
  localparam logic [7:0] ADDR_Y_CMP_P  = 8'h18;
  localparam logic [7:0] ADDR_Y_CMP_N  = 8'h1C;

  // Mode register fields, one nibble per axis
  localparam int unsigned MODE_STATUS_OUT = 0;
  localparam int unsigned MODE_INPOS_EN   = 1;
  localparam int unsigned MODE_INPOS_HIGH = 2;
  localparam int unsigned MODE_CMP_REAL   = 3;
  localparam int unsigned MODE_X_BASE     = 0;
  localparam int unsigned MODE_Y_BASE     = 8;
  localparam int unsigned MODE_INTERP_X   = 16;
  localparam int unsigned MODE_INTERP_Y   = 17;

  // Output data byte lanes and input status field
  localparam int unsigned OUT_X_LSB = 0;
  localparam int unsigned OUT_Y_LSB = 8;
  localparam int unsigned GPI_LSB   = 8;
  localparam int unsigned GPI_W     = 6;
  localparam int unsigned INTERP_BIT = 5;

  // Status output bit positions within a byte
  localparam int unsigned SO_DECEL  = 7;
  localparam int unsigned SO_CONST  = 6;
  localparam int unsigned SO_ACCEL  = 5;
  localparam int unsigned SO_DRIVE  = 4;
  localparam int unsigned SO_CMP_N  = 3;
  localparam int unsigned SO_CMP_P  = 2;
  localparam int unsigned SO_JERK_D = 1;
  localparam int unsigned SO_JERK_A = 0;

  // Reset values
  localparam logic [15:0] OUT_DATA_RST = 16'h0000;
  localparam logic [31:0] MODE_RST     = 32'h0000_0000;
  localparam logic [31:0] CMP_P_RST    = 32'h7FFF_FFFF;
  localparam logic [31:0] CMP_N_RST    = 32'h8000_0000;

  localparam int unsigned POS_W = 32;

  typedef struct packed {
    logic              drive_busy;
    logic              pulse_active;
    logic              accel;
    logic              const_speed;
    logic              decel;
    logic              jerk_inc;
    logic              jerk_dec;
    logic [POS_W-1:0]  logic_pos;
    logic [POS_W-1:0]  real_pos;
  } asgio_motion_t;

  typedef struct packed {
    logic status_out;
    logic inpos_en;
    logic inpos_high;
    logic cmp_real;
  } asgio_cfg_t;

endpackage
`default_nettype wire

//--- rtl/asgio_axis.sv
/*
  One axis of general outputs: register byte or motion status byte.
  Assumes motion status and config on pclk; in-position level synced.
*/
`timescale 1ns/100ps
`default_nettype none
module asgio_axis #(
  parameter int unsigned POS_W = asgio_pkg::POS_W
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Control
  input  wire asgio_pkg::asgio_cfg_t cfg,
  input  wire logic [7:0]            out_data,
  input  wire logic [POS_W-1:0]      cmp_pos,
  input  wire logic [POS_W-1:0]      cmp_neg,
  // Motion side
  input  wire asgio_pkg::asgio_motion_t motion,
  input  wire logic                  inpos_active,
  // Pins
  output var  logic [7:0]            gen_out
);

  if (POS_W < 2 || POS_W > asgio_pkg::POS_W) begin : g_bad_width
    $error("asgio_axis: POS_W out of range");
  end

  logic             drive_hold;
  logic             cmp_n_state;
  logic             cmp_p_state;
  logic             next_drive;
  logic             next_cmp_n;
  logic             next_cmp_p;
  logic [POS_W-1:0] sel_pos;
  logic [7:0]       status_byte;

  assign sel_pos = cfg.cmp_real ? motion.real_pos[POS_W-1:0]
                                : motion.logic_pos[POS_W-1:0];

  always_comb begin
    // With in-position enabled, drive stays up after pulses until in-position arrives
    next_drive = motion.pulse_active |
                 (drive_hold & cfg.inpos_en & ~inpos_active);
    // Equal value keeps the last answer, avoiding chatter at the bound
    if ($signed(sel_pos) < $signed(cmp_neg)) begin
      next_cmp_n = 1'b1;
    end else if ($signed(sel_pos) > $signed(cmp_neg)) begin
      next_cmp_n = 1'b0;
    end else begin
      next_cmp_n = cmp_n_state;
    end
    if ($signed(sel_pos) > $signed(cmp_pos)) begin
      next_cmp_p = 1'b1;
    end else if ($signed(sel_pos) < $signed(cmp_pos)) begin
      next_cmp_p = 1'b0;
    end else begin
      next_cmp_p = cmp_p_state;
    end
    status_byte = '0;
    status_byte[asgio_pkg::SO_DECEL]  = motion.drive_busy & motion.decel;
    status_byte[asgio_pkg::SO_CONST]  =
      motion.drive_busy & motion.const_speed;
    status_byte[asgio_pkg::SO_ACCEL]  = motion.drive_busy & motion.accel;
    status_byte[asgio_pkg::SO_DRIVE]  = next_drive;
    status_byte[asgio_pkg::SO_CMP_N]  = next_cmp_n;
    status_byte[asgio_pkg::SO_CMP_P]  = next_cmp_p;
    status_byte[asgio_pkg::SO_JERK_D] =
      motion.drive_busy & motion.jerk_dec;
    status_byte[asgio_pkg::SO_JERK_A] =
      motion.drive_busy & motion.jerk_inc;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_hold  <= 1'b0;
      cmp_n_state <= 1'b0;
      cmp_p_state <= 1'b0;
    end else begin
      drive_hold  <= next_drive;
      cmp_n_state <= next_cmp_n;
      cmp_p_state <= next_cmp_p;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_out <= 8'h00;
    end else if (cfg.status_out) begin
      gen_out <= status_byte;
    end else begin
      gen_out <= out_data;
    end
  end

endmodule
`default_nettype wire

//--- rtl/asgio_top.sv
/*
  Per-axis general I/O of a two-axis pulse-train motion controller:
  APB register slave, input synchronisers, two axis output units and
  the external interpolation pulse edge detector.
  Assumes motion status on pclk; general inputs arrive from pins.
*/
// Summary of operation
// - Outputs follow output-data byte when status mode off; low at reset
// - Descend output high while drive executing and decelerating
// - Constant-speed output high while drive executing at constant speed
// - Ascend output high while drive executing and accelerating
// - Drive-active output high while drive pulses are emitted
// - With in-position enabled, drive-active holds until in-position active
// - Negative-compare high below negative value, low above it
// - Positive-compare high above positive value, low below it
// - Jerk-descend high while S-curve rate decreases
// - Jerk-ascend high while S-curve rate increases
// - Six general inputs shown in bits 13 to 8 of status registers
// - Each falling interpolation pulse edge steps each enabled axis once
`timescale 1ns/100ps
`default_nettype none
module asgio_top (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output var  logic [31:0]              prdata,
  output var  logic                     pready,
  output var  logic                     pslverr,
  // Motion core status
  input  wire asgio_pkg::asgio_motion_t motion_x,
  input  wire asgio_pkg::asgio_motion_t motion_y,
  // General input pins
  input  wire logic [5:0]               gen_in_x,
  input  wire logic [5:0]               gen_in_y,
  input  wire logic                     servo_in_position_x,
  input  wire logic                     servo_in_position_y,
  // General output pins
  output var  logic [7:0]               gen_out_x,
  output var  logic [7:0]               gen_out_y,
  // Interpolation step pulses
  output var  logic                     interp_step_x,
  output var  logic                     interp_step_y
);

  logic [15:0] output_data_reg;
  logic [31:0] mode_reg;
  logic [31:0] x_cmp_pos;
  logic [31:0] x_cmp_neg;
  logic [31:0] y_cmp_pos;
  logic [31:0] y_cmp_neg;
  logic [5:0]  gpi_x_meta;
  logic [5:0]  gpi_x_sync;
  logic [5:0]  gpi_y_meta;
  logic [5:0]  gpi_y_sync;
  logic [1:0]  inpos_meta;
  logic [1:0]  inpos_sync;
  logic        interp_prev;
  logic        interp_fall;
  logic        wr_en;
  logic        inpos_act_x;
  logic        inpos_act_y;
  logic [31:0] next_rdata;
  logic [31:0] x_input_status_reg;
  logic [31:0] y_input_status_reg;
  asgio_pkg::asgio_cfg_t cfg_x;
  asgio_pkg::asgio_cfg_t cfg_y;

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      asgio_pkg::ADDR_OUT_DATA,
      asgio_pkg::ADDR_MODE,
      asgio_pkg::ADDR_X_STATUS,
      asgio_pkg::ADDR_Y_STATUS,
      asgio_pkg::ADDR_X_CMP_P,
      asgio_pkg::ADDR_X_CMP_N,
      asgio_pkg::ADDR_Y_CMP_P,
      asgio_pkg::ADDR_Y_CMP_N: is_mapped = 1'b1;
      default:                 is_mapped = 1'b0;
    endcase
  endfunction

  function automatic asgio_pkg::asgio_cfg_t mode_cfg(
    input logic [31:0] m,
    input int unsigned base
  );
    asgio_pkg::asgio_cfg_t c;
    c.status_out = m[base + asgio_pkg::MODE_STATUS_OUT];
    c.inpos_en   = m[base + asgio_pkg::MODE_INPOS_EN];
    c.inpos_high = m[base + asgio_pkg::MODE_INPOS_HIGH];
    c.cmp_real   = m[base + asgio_pkg::MODE_CMP_REAL];
    return c;
  endfunction

  assign cfg_x = mode_cfg(mode_reg, asgio_pkg::MODE_X_BASE);
  assign cfg_y = mode_cfg(mode_reg, asgio_pkg::MODE_Y_BASE);

  // Pin inputs pass two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpi_x_meta <= 6'h00;
      gpi_x_sync <= 6'h00;
      gpi_y_meta <= 6'h00;
      gpi_y_sync <= 6'h00;
      inpos_meta <= 2'h0;
      inpos_sync <= 2'h0;
    end else begin
      gpi_x_meta <= gen_in_x;
      gpi_x_sync <= gpi_x_meta;
      gpi_y_meta <= gen_in_y;
      gpi_y_sync <= gpi_y_meta;
      inpos_meta <= {servo_in_position_y, servo_in_position_x};
      inpos_sync <= inpos_meta;
    end
  end

  // Active level of the in-position pin is software-selected
  assign inpos_act_x = inpos_sync[0] ~^ cfg_x.inpos_high;
  assign inpos_act_y = inpos_sync[1] ~^ cfg_y.inpos_high;

  assign x_input_status_reg = {18'h0_0000, gpi_x_sync, 8'h00};
  assign y_input_status_reg = {18'h0_0000, gpi_y_sync, 8'h00};

  // Interpolation pulse shares the X general input 5 pin
  assign interp_fall = interp_prev & ~gpi_x_sync[asgio_pkg::INTERP_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interp_prev   <= 1'b0; // Same as synced reset level, no false fall
      interp_step_x <= 1'b0;
      interp_step_y <= 1'b0;
    end else begin
      interp_prev   <= gpi_x_sync[asgio_pkg::INTERP_BIT];
      interp_step_x <= interp_fall & mode_reg[asgio_pkg::MODE_INTERP_X];
      interp_step_y <= interp_fall & mode_reg[asgio_pkg::MODE_INTERP_Y];
    end
  end

  // APB: one access cycle, answer registered from the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= ~is_mapped(paddr);
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  always_comb begin
    case (paddr)
      asgio_pkg::ADDR_OUT_DATA: next_rdata = {16'h0000, output_data_reg};
      asgio_pkg::ADDR_MODE:     next_rdata = mode_reg;
      asgio_pkg::ADDR_X_STATUS: next_rdata = x_input_status_reg;
      asgio_pkg::ADDR_Y_STATUS: next_rdata = y_input_status_reg;
      asgio_pkg::ADDR_X_CMP_P:  next_rdata = x_cmp_pos;
      asgio_pkg::ADDR_X_CMP_N:  next_rdata = x_cmp_neg;
      asgio_pkg::ADDR_Y_CMP_P:  next_rdata = y_cmp_pos;
      asgio_pkg::ADDR_Y_CMP_N:  next_rdata = y_cmp_neg;
      default:                  next_rdata = 32'h0000_0000;
    endcase
  end

  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_data_reg <= asgio_pkg::OUT_DATA_RST;
      mode_reg        <= asgio_pkg::MODE_RST;
      x_cmp_pos       <= asgio_pkg::CMP_P_RST;
      x_cmp_neg       <= asgio_pkg::CMP_N_RST;
      y_cmp_pos       <= asgio_pkg::CMP_P_RST;
      y_cmp_neg       <= asgio_pkg::CMP_N_RST;
    end else if (wr_en) begin
      case (paddr)
        asgio_pkg::ADDR_OUT_DATA: output_data_reg <= pwdata[15:0];
        asgio_pkg::ADDR_MODE:     mode_reg        <= pwdata;
        asgio_pkg::ADDR_X_CMP_P:  x_cmp_pos       <= pwdata;
        asgio_pkg::ADDR_X_CMP_N:  x_cmp_neg       <= pwdata;
        asgio_pkg::ADDR_Y_CMP_P:  y_cmp_pos       <= pwdata;
        asgio_pkg::ADDR_Y_CMP_N:  y_cmp_neg       <= pwdata;
        default: ;
      endcase
    end
  end

  asgio_axis #(
    .POS_W(asgio_pkg::POS_W)
  ) u_axis_x (
    .pclk         (pclk),
    .presetn      (presetn),
    .cfg          (cfg_x),
    .out_data     (output_data_reg[asgio_pkg::OUT_X_LSB +: 8]),
    .cmp_pos      (x_cmp_pos),
    .cmp_neg      (x_cmp_neg),
    .motion       (motion_x),
    .inpos_active (inpos_act_x),
    .gen_out      (gen_out_x)
  );

  asgio_axis #(
    .POS_W(asgio_pkg::POS_W)
  ) u_axis_y (
    .pclk         (pclk),
    .presetn      (presetn),
    .cfg          (cfg_y),
    .out_data     (output_data_reg[asgio_pkg::OUT_Y_LSB +: 8]),
    .cmp_pos      (y_cmp_pos),
    .cmp_neg      (y_cmp_neg),
    .motion       (motion_y),
    .inpos_active (inpos_act_y),
    .gen_out      (gen_out_y)
  );

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_data_mode_x: assert property (
    !$past(cfg_x.status_out) |-> gen_out_x == $past(output_data_reg[7:0]))
    else $error("X outputs do not follow output data");

  a_data_mode_y: assert property (
    !$past(cfg_y.status_out) |-> gen_out_y == $past(output_data_reg[15:8]))
    else $error("Y outputs do not follow output data");

  a_decel_out: assert property (
    $past(cfg_x.status_out) |->
      gen_out_x[7] == $past(motion_x.drive_busy && motion_x.decel))
    else $error("Descend output wrong");

  a_const_out: assert property (
    $past(cfg_y.status_out) |->
      gen_out_y[6] == $past(motion_y.drive_busy && motion_y.const_speed))
    else $error("Constant-speed output wrong");

  a_accel_out: assert property (
    $past(cfg_x.status_out) |->
      gen_out_x[5] == $past(motion_x.drive_busy && motion_x.accel))
    else $error("Ascend output wrong");

  a_drive_pulse: assert property (
    cfg_x.status_out && motion_x.pulse_active |=> gen_out_x[4])
    else $error("Drive output low during pulses");

  a_drive_hold: assert property (
    $past(cfg_x.status_out) && cfg_x.status_out && gen_out_x[4] &&
      cfg_x.inpos_en && !inpos_act_x |=> gen_out_x[4])
    else $error("Drive output dropped before in-position");

  a_drive_release: assert property (
    cfg_x.status_out && !cfg_x.inpos_en && !motion_x.pulse_active
      |=> !gen_out_x[4])
    else $error("Drive output held without in-position enable");

  a_neg_compare: assert property (
    cfg_x.status_out && !cfg_x.cmp_real &&
      $signed(motion_x.logic_pos) < $signed(x_cmp_neg) |=> gen_out_x[3])
    else $error("Negative compare not high below bound");

  a_pos_compare: assert property (
    cfg_x.status_out && cfg_x.cmp_real &&
      $signed(motion_x.real_pos) < $signed(x_cmp_pos) |=> !gen_out_x[2])
    else $error("Positive compare not low below bound");

  a_jerk_down: assert property (
    cfg_y.status_out && motion_y.drive_busy && motion_y.jerk_dec
      |=> gen_out_y[1])
    else $error("Jerk-descend output low");

  a_jerk_up: assert property (
    cfg_y.status_out && !motion_y.drive_busy |=> !gen_out_y[0])
    else $error("Jerk-ascend high without drive");

  a_input_status: assert property (
    psel && !penable && !pwrite && paddr == asgio_pkg::ADDR_X_STATUS
      |=> prdata == {18'h0_0000, $past(gpi_x_sync), 8'h00})
    else $error("X input status read wrong");

  a_interp_step: assert property (
    interp_step_x |-> $past(interp_fall) &&
      $past(mode_reg[asgio_pkg::MODE_INTERP_X]) ##1 !interp_step_x)
    else $error("Interpolation step without falling edge");

  a_interp_edge: assert property (
    $fell(gpi_x_sync[5]) && mode_reg[asgio_pkg::MODE_INTERP_Y]
      |=> interp_step_y)
    else $error("Falling edge missed");

  a_interp_gate: assert property (
    !mode_reg[asgio_pkg::MODE_INTERP_Y] |=> !interp_step_y)
    else $error("Interpolation step while disabled");

  a_decel_out_y: assert property (
    $past(cfg_y.status_out) |->
      gen_out_y[7] == $past(motion_y.drive_busy && motion_y.decel))
    else $error("Y descend output wrong");

  a_drive_hold_y: assert property (
    $past(cfg_y.status_out) && cfg_y.status_out && gen_out_y[4] &&
      cfg_y.inpos_en && !inpos_act_y |=> gen_out_y[4])
    else $error("Y drive output dropped before in-position");

  a_neg_compare_y: assert property (
    cfg_y.status_out && cfg_y.cmp_real &&
      $signed(motion_y.real_pos) > $signed(y_cmp_neg) |=> !gen_out_y[3])
    else $error("Y negative compare not low above bound");

  a_pos_compare_y: assert property (
    cfg_y.status_out && !cfg_y.cmp_real &&
      $signed(motion_y.logic_pos) > $signed(y_cmp_pos) |=> gen_out_y[2])
    else $error("Y positive compare not high above bound");

  a_jerk_up_x: assert property (
    cfg_x.status_out && motion_x.drive_busy && motion_x.jerk_inc
      |=> gen_out_x[0])
    else $error("Jerk-ascend output low");

  a_input_status_y: assert property (
    psel && !penable && !pwrite && paddr == asgio_pkg::ADDR_Y_STATUS
      |=> prdata == {18'h0_0000, $past(gpi_y_sync), 8'h00})
    else $error("Y input status read wrong");

  c_drive_hold: cover property (
    cfg_x.status_out && cfg_x.inpos_en && $fell(motion_x.pulse_active)
      ##1 gen_out_x[4] ##1 gen_out_x[4]);

  c_interp_step: cover property (interp_step_x && interp_step_y);

  c_status_read: cover property (
    pready && !pslverr && paddr == asgio_pkg::ADDR_Y_STATUS && !pwrite);

  c_decel_phase: cover property (cfg_y.status_out ##1 gen_out_y[7]);

endmodule
`default_nettype wire

//--- tb/asgio_motion_model.sv
/*
  Far-side model: motion core status flags, positions and servo
  in-position pins for both axes.
  Assumes the pclk domain; the bench picks random or commanded motion.
*/
`timescale 1ns/100ps
`default_nettype none
module asgio_motion_model #(
  parameter int unsigned SETTLE = 8
) (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // Command from bench
  input  wire logic                      run,
  input  wire logic                      busy_req,
  input  wire logic                      inpos_hi,
  // Motion and servo side
  output var  asgio_pkg::asgio_motion_t  motion_x,
  output var  asgio_pkg::asgio_motion_t  motion_y,
  output wire logic                      servo_in_position_x,
  output wire logic                      servo_in_position_y
);
  int unsigned cx;
  int unsigned cy;

  // Phase flags drawn independently, so busy gating is exercised too
  function automatic asgio_pkg::asgio_motion_t roll(logic r, logic b);
    logic [31:0] w;
    w = $urandom;
    return {r ? w[6:0] : {b, b, 5'h00}, $urandom, $urandom};
  endfunction

  // Servo settles a while after the last pulse, like a real loop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motion_x <= '0;
      motion_y <= '0;
      cx <= 0;
      cy <= 0;
    end else begin
      motion_x <= roll(run, busy_req);
      motion_y <= roll(run, busy_req);
      cx <= motion_x.pulse_active ? 0 : (cx < SETTLE ? cx + 1 : cx);
      cy <= motion_y.pulse_active ? 0 : (cy < SETTLE ? cy + 1 : cy);
    end
  end

  assign servo_in_position_x = (cx >= SETTLE) ~^ inpos_hi;
  assign servo_in_position_y = (cy >= SETTLE) ~^ inpos_hi;
endmodule
`default_nettype wire

//--- tb/test_axis_status_general_io.sv
/*
  Self-checking bench for the per-axis general I/O block.
  Assumes an APB master here, the motion model on the far side.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module test_axis_status_general_io;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, t, mode = 0;
  logic [31:0] cmpv [4] = '{32'h7FFF_FFFF, 32'h8000_0000,
                            32'h7FFF_FFFF, 32'h8000_0000};
  logic [15:0] od = 0;
  logic [5:0]  gen_in_x = 0, gen_in_y = 0;
  logic [7:0]  gen_out_x, gen_out_y, ex, ey;
  logic        pready, pslverr, e, interp_step_x, interp_step_y;
  logic        sipx, sipy, run = 0, busy_req = 0, inpos_hi = 0, mon = 0;
  asgio_pkg::asgio_motion_t motion_x, motion_y;
  int          fails = 0, n_checks = 0, cyc = 0, n;
  integer      sx = 0, sy = 0, bx, by;
  logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C};
  logic [31:0] mt [4] = '{32'h0000_0000, 32'h0000_0901,
                          32'h0000_0109, 32'h0000_0001};

  asgio_top u_asgio_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motion_x(motion_x), .motion_y(motion_y), .gen_in_x(gen_in_x),
    .gen_in_y(gen_in_y), .servo_in_position_x(sipx),
    .servo_in_position_y(sipy), .gen_out_x(gen_out_x),
    .gen_out_y(gen_out_y), .interp_step_x(interp_step_x),
    .interp_step_y(interp_step_y));
  asgio_motion_model u_asgio_motion_model (.pclk(pclk), .presetn(presetn),
    .run(run), .busy_req(busy_req), .inpos_hi(inpos_hi),
    .motion_x(motion_x), .motion_y(motion_y),
    .servo_in_position_x(sipx), .servo_in_position_y(sipy));

  always #2 pclk = ~pclk;

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Status byte or data byte, as the axis mode nibble selects
  function automatic logic [7:0] exp_out(asgio_pkg::asgio_motion_t m,
    logic [3:0] c, logic [7:0] d, logic [31:0] cp, logic [31:0] cn);
    logic signed [31:0] p;
    logic b;
    b = m.drive_busy;
    p = c[asgio_pkg::MODE_CMP_REAL] ? m.real_pos : m.logic_pos;
    if (!c[asgio_pkg::MODE_STATUS_OUT]) return d;
    return {m.decel & b, m.const_speed & b, m.accel & b,
      m.pulse_active, p < $signed(cn), p > $signed(cp),
      m.jerk_dec & b, m.jerk_inc & b};
  endfunction

  always @(negedge pclk) begin
    sx += interp_step_x;
    sy += interp_step_y;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end

  always @(posedge pclk) begin
    if (mon) begin
      `CHK(gen_out_x, ex)
      `CHK(gen_out_y, ey)
    end
    ex = exp_out(motion_x, mode[3:0], od[7:0], cmpv[0], cmpv[1]);
    ey = exp_out(motion_y, mode[11:8], od[15:8], cmpv[2], cmpv[3]);
  end

  initial begin
    void'($urandom(32'h26739f45));
    tick(16);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(0, ra[i], 0);
      `CHK(q, i < 2 ? 32'h0000_0000 : cmpv[i - 2])
    end
    `CHK({gen_out_y, gen_out_x}, 16'h0000)
    apb(0, 8'h24, 0);
    `CHK({e, q}, {1'b1, 32'h0000_0000})
    $display("reset test done");
    // Random compare bounds; equal positions are too unlikely to matter
    for (int i = 0; i < 4; i++) begin
      cmpv[i] = $urandom;
      apb(1, asgio_pkg::ADDR_X_CMP_P + 8'(4 * i), cmpv[i]);
    end
    run <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      mon <= 1'b0;
      t = $urandom;
      apb(1, asgio_pkg::ADDR_OUT_DATA, t);
      od <= t[15:0];
      apb(1, asgio_pkg::ADDR_MODE, mt[k]);
      mode <= mt[k];
      tick(2);
      mon <= 1'b1;
      tick(150);
    end
    mon <= 1'b0;
    run <= 1'b0;
    $display("output test done");
    for (int p = 0; p < 2; p++) begin
      inpos_hi <= p[0];
      apb(1, asgio_pkg::ADDR_MODE, 32'h0000_0303 + 32'h0000_0404 * p);
      busy_req <= 1'b1;
      tick(4);
      `CHK(gen_out_x[4], 1'b1)
      busy_req <= 1'b0;
      tick(6);
      `CHK({gen_out_y[4], gen_out_x[4]}, 2'b11)
      n = 0;
      while (gen_out_x[4] !== 1'b0 && n < 20) begin
        tick(1);
        n++;
      end
      `CHK(gen_out_x[4], 1'b0)
    end
    apb(1, asgio_pkg::ADDR_MODE, 32'h0000_0001);
    busy_req <= 1'b1;
    tick(4);
    busy_req <= 1'b0;
    tick(3);
    `CHK(gen_out_x[4], 1'b0)
    $display("drive test done");
    for (int i = 0; i < 8; i++) begin
      t = i == 0 ? 32'h0000_3F00 : (i == 1 ? 32'h0000_003F : $urandom);
      gen_in_x <= t[5:0];
      gen_in_y <= t[13:8];
      tick(4);
      apb(0, asgio_pkg::ADDR_X_STATUS, 0);
      `CHK(q[13:8], t[5:0])
      apb(0, asgio_pkg::ADDR_Y_STATUS, 0);
      `CHK(q[13:8], t[13:8])
    end
    $display("input test done");
    gen_in_x <= 6'h20;
    for (int k = 0; k < 2; k++) begin
      apb(1, asgio_pkg::ADDR_MODE, k == 0 ? 32'h0003_0000 : 32'h0001_0000);
      tick(4);
      bx = sx;
      by = sy;
      // Short low pulses are the hard case for the edge detector
      for (int j = 0; j < 6; j++) begin
        gen_in_x[5] <= 1'b0;
        tick(1 + $urandom % 3);
        gen_in_x[5] <= 1'b1;
        tick(2 + $urandom % 3);
      end
      tick(6);
      `CHK(sx - bx, 6)
      `CHK(sy - by, k == 0 ? 6 : 0)
    end
    $display("interpolation test done");
    results();
  end
endmodule
`default_nettype wire
